// File: tb/flash_dev_model.sv
// Behavioural model of the parallel flash device
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3,  // Arbitrary value
  parameter logic [7:0] PROT_MAP = 8'h24,
  parameter int         BUSY_NS  = 2000
) (
  // Flash pins
  input  wire logic [18:0] flashAddr,
  input  wire logic [7:0]  dqOut,
  input  wire logic        chipSel_n,
  input  wire logic        outGate_n,
  input  wire logic        writeStb_n,
  output wire logic [7:0]  dqIn
);
  logic [7:0]  mem [logic [18:0]];
  logic [18:0] addr_q;
  logic [7:0]  pgD_q, last_q, rdVal;
  logic [2:0]  st_q;
  logic        armed_q, busy_q, err_q, erase_q, asel_q;
  wire         wrOn = !chipSel_n && !writeStb_n && outGate_n;
  initial begin
    {st_q, armed_q, busy_q, err_q, erase_q, asel_q} = 8'h00;
    last_q = 8'h00;
  end
  function automatic logic [7:0] rd(input logic [18:0] a);
    rd = mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2AA;
    if (busy_q) begin
      if (err_q && d == 8'hF0) {busy_q, err_q} = 2'b00;
    end else if (d == 8'hF0) {st_q, asel_q} = 4'h0;
    else case (st_q)
      0: st_q = (u1 && d == 8'hAA) ? 3'd1 : 3'd0;
      1: st_q = (u2 && d == 8'h55) ? 3'd2 : 3'd0;
      2: begin
        st_q = !u1 ? 3'd0 : d == 8'hA0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
        if (u1 && d == 8'h90) asel_q = 1'b1;
      end
      3: begin
        st_q = 3'd0;
        pgD_q = d;
        erase_q = 1'b0;
        err_q = |(d & ~rd(a));
        mem[a] = d & rd(a);
        busy_q = 1'b1;
      end
      4: st_q = (u1 && d == 8'hAA) ? 3'd5 : 3'd0;
      5: st_q = (u2 && d == 8'h55) ? 3'd6 : 3'd0;
      default: begin
        st_q = 3'd0;
        if (u1 && d == 8'h10) {erase_q, busy_q} = 2'b11;
      end
    endcase
  endtask
  always @(posedge wrOn) begin
    addr_q = flashAddr;
    armed_q = 1'b1;
  end
  always @(negedge wrOn) if (armed_q) cmd(addr_q, dqOut);
  always @(posedge busy_q) if (!err_q) begin
    #(BUSY_NS);
    if (erase_q) mem.delete();
    busy_q = 1'b0;
  end
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @(*) begin
    if (busy_q) rdVal = {erase_q ? 1'b0 : ~pgD_q[7], 1'b0, err_q, 5'h00};
    else if (asel_q) rdVal = flashAddr[7:0] == 8'h00 ? MFR_CODE :
      flashAddr[7:0] == 8'h01 ? DEV_CODE : {7'h00, PROT_MAP[flashAddr[18:16]]};
    else rdVal = rd(flashAddr);
  end
  always @(posedge outGate_n) last_q = rdVal;
  assign dqIn = (!chipSel_n && !outGate_n) ? rdVal : ~last_q;
endmodule // flash_dev_model
`default_nettype wire

// File: tb/flash_host_asserts.sv
// Assertions on the flash host controller pins and user port
`timescale 1ns/1ns
`default_nettype none
module flash_host_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // User port
  input wire logic        opValid,
  input wire logic        opReady,
  input wire logic        opDone,
  input wire logic        opError,
  input wire logic        busy,
  // Flash pins
  input wire logic [18:0] flashAddr,
  input wire logic [7:0]  dqOut,
  input wire logic        dqOe_n,
  input wire logic        chipSel_n,
  input wire logic        outGate_n,
  input wire logic        writeStb_n
);
  // ----------------------------------------------------------------
  // Reset command seen since last accept
  // ----------------------------------------------------------------
  logic sawReset_q;
  always @(posedge clk) begin
    if (sys_rst || (opValid && opReady)) sawReset_q <= 1'b0;
    else if (!writeStb_n && dqOut == 8'hF0) sawReset_q <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  write_levels_a: assert property (!writeStb_n |-> !chipSel_n && outGate_n && !dqOe_n)
    else $error("write strobe without select, high gate and data drive");
  read_levels_a: assert property (!outGate_n |-> !chipSel_n && writeStb_n && dqOe_n)
    else $error("read gate overlaps a write");
  write_hold_a: assert property (!writeStb_n && !$past(writeStb_n) |-> $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved under write strobe");
  strobe_width_a: assert property ($fell(writeStb_n) |-> !writeStb_n[*8])
    else $error("write strobe too short");
  timeout_reset_a: assert property (opDone && opError |-> sawReset_q)
    else $error("failed operation ended without reset command");
  busy_end_a: assert property ($fell(busy) |-> ##[0:2] opDone)
    else $error("busy dropped without completion");
  idle_pins_a: assert property (opReady |-> chipSel_n && writeStb_n && outGate_n && dqOe_n)
    else $error("pins active while idle");
  done_pulse_a: assert property (opDone |=> !opDone && !busy)
    else $error("completion pulse too long or busy after it");
  cover property (opDone && !opError);
  cover property (opDone && opError);
  cover property ($rose(busy));
endmodule // flash_host_asserts

bind flash_command_state_machine flash_host_asserts chkU (
  .clk(clk), .sys_rst(sys_rst), .opValid(opValid), .opReady(opReady), .opDone(opDone),
  .opError(opError), .busy(busy), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe_n(dqOe_n),
  .chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStb_n(writeStb_n)
);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.vh"
module testbench;
  localparam logic [7:0] MFR  = 8'h5A;  // Arbitrary value
  localparam logic [7:0] DEV  = 8'hC3;  // Arbitrary value
  localparam logic [7:0] PROT = 8'h24;
  logic        clk, sys_rst, opValid, opReady, opDone, opError, busy, autoselActive, sawBusy;
  logic [2:0]  opCode;
  logic [18:0] opAddr, flashAddr;
  logic [7:0]  opData, opRdData, dqOut, dqIn;
  logic        dqOe_n, chipSel_n, outGate_n, writeStb_n;
  int          errorCnt = 0;
  int          checkCount = 0;
  flash_command_state_machine dut_u (
    .clk(clk), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
    .opData(opData), .opReady(opReady), .opDone(opDone), .opError(opError),
    .opRdData(opRdData), .busy(busy), .autoselActive(autoselActive), .flashAddr(flashAddr),
    .dqOut(dqOut), .dqOe_n(dqOe_n), .dqIn(dqIn), .chipSel_n(chipSel_n),
    .outGate_n(outGate_n), .writeStb_n(writeStb_n)
  );
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT_MAP(PROT)) devU (
    .flashAddr(flashAddr), .dqOut(dqOut), .chipSel_n(chipSel_n), .outGate_n(outGate_n),
    .writeStb_n(writeStb_n), .dqIn(dqIn)
  );
  always #2 clk = ~clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic doOp(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    sawBusy = 1'b0;
    while (opReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    opCode <= c;
    opAddr <= a;
    opData <= d;
    opValid <= 1'b1;
    @(posedge clk);
    opValid <= 1'b0;
    while (opDone !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
      if (busy === 1'b1) sawBusy = 1'b1;
    end
    if (n >= 5000) chk("operation completion", 8'h01, 8'h00);
  endtask
  task automatic rdChk(input logic [18:0] a, input logic [7:0] exp);
    doOp(`OP_READ, a, 8'h00);
    chk("read data", exp, opRdData);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sProgram();
    rdChk(19'h12345, 8'hFF);
    doOp(`OP_PROGRAM, 19'h12345, 8'h3C);
    chk("busy during program", 8'h01, {7'h00, sawBusy});
    chk("program error flag", 8'h00, {7'h00, opError});
    rdChk(19'h12345, 8'h3C);
    doOp(`OP_POLL, 19'h12345, 8'h00);
    chk("poll code read data", 8'h3C, opRdData);
  endtask
  task automatic sProgramFail();
    doOp(`OP_PROGRAM, 19'h12345, 8'hC3);
    chk("timeout error flag", 8'h01, {7'h00, opError});
    rdChk(19'h12345, 8'h00);
    rdChk(19'h00100, 8'hFF);
  endtask
  task automatic sAutoselect();
    doOp(`OP_AUTOSELECT, 19'h00000, 8'h00);
    chk("autoselect mode", 8'h01, {7'h00, autoselActive});
    rdChk(19'h00000, MFR);
    rdChk(19'h7AB01, DEV);
    rdChk(19'h5CD00, MFR);
    for (int s = 0; s < 8; s++) rdChk({s[2:0], 16'h0002}, {7'h00, PROT[s]});
    doOp(`OP_RESET, 19'h6ABCD, 8'h00);
    chk("autoselect left", 8'h00, {7'h00, autoselActive});
    rdChk(19'h12345, 8'h00);
  endtask
  task automatic sErase();
    doOp(`OP_CHIP_ERASE, 19'h00000, 8'h00);
    chk("busy during erase", 8'h01, {7'h00, sawBusy});
    chk("erase error flag", 8'h00, {7'h00, opError});
    rdChk(19'h12345, 8'hFF);
    doOp(`OP_PROGRAM, 19'h7FFFF, 8'hA5);
    rdChk(19'h7FFFF, 8'hA5);
  endtask
  task automatic closeOut();
    $display("Checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    opValid = 1'b0;
    opCode = 3'h0;
    opAddr = 19'h00000;
    opData = 8'h00;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    sProgram();
    sProgramFail();
    sAutoselect();
    sErase();
    closeOut();
  end
  initial begin
    #200000;
    errorCnt++;
    closeOut();
  end
endmodule // testbench
`default_nettype wire

// File: verilog/bus_cycle_engine.v
// One strobed read or write cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.vh"

module bus_cycle_engine (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Cycle request
  input  wire        start,
  input  wire        isWrite,
  input  wire [18:0] addrIn,
  input  wire [7:0]  dataIn,
  output reg         done,
  output reg  [7:0]  rdData,
  // Flash pins
  output reg  [18:0] flashAddr,
  output reg  [7:0]  dqOut,
  output reg         dqOe_n,
  input  wire [7:0]  dqIn,
  output reg         chipSel_n,
  output reg         outGate_n,
  output reg         writeStb_n
);

  localparam S_IDLE  = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_PULSE = 2'h2;
  localparam S_HOLD  = 2'h3;

  localparam [31:0] SETUP_W = `SETUP_CYC;
  localparam [31:0] PULSE_W = `PULSE_CYC;
  localparam [31:0] HOLD_W  = `HOLD_CYC;

  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg       wr_q;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    done <= 1'b0;
    if (sys_rst) begin
      st_q       <= S_IDLE;
      cnt_q      <= 4'h0;
      wr_q       <= 1'b0;
      rdData     <= 8'h00;
      flashAddr  <= 19'h00000;
      dqOut      <= 8'h00;
      dqOe_n     <= 1'b1;
      chipSel_n  <= 1'b1;
      outGate_n  <= 1'b1;
      writeStb_n <= 1'b1;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (start) begin
            wr_q      <= isWrite;
            flashAddr <= addrIn;
            dqOut     <= dataIn;
            dqOe_n    <= ~isWrite;
            outGate_n <= 1'b1;
            cnt_q     <= SETUP_W[3:0];
            st_q      <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            // Select falls with write strobe on a write (gate stays high), or with output gate on a read
            chipSel_n  <= 1'b0;
            writeStb_n <= ~wr_q;
            outGate_n  <= wr_q;
            cnt_q      <= PULSE_W[3:0];
            st_q       <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            rdData     <= dqIn;
            chipSel_n  <= 1'b1;
            writeStb_n <= 1'b1;
            outGate_n  <= 1'b1;
            cnt_q      <= HOLD_W[3:0];
            st_q       <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            dqOe_n <= 1'b1;
            done   <= 1'b1;
            st_q   <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule // bus_cycle_engine
`default_nettype wire

// File: verilog/flash_command_state_machine.v
// Host controller issuing command sequences to a parallel flash
// Summary of operation
// - Host writes with select, strobe low, gate high
// - Host sends reset on timeout or on a reset request
// - Program is four writes then embedded run
// - Chip erase is six writes
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.vh"

module flash_command_state_machine (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // User request
  input  wire        opValid,
  input  wire [2:0]  opCode,
  input  wire [18:0] opAddr,
  input  wire [7:0]  opData,
  output reg         opReady,
  output reg         opDone,
  output reg         opError,
  output reg  [7:0]  opRdData,
  output reg         busy,
  output reg         autoselActive,
  // Flash pins
  output wire [18:0] flashAddr,
  output wire [7:0]  dqOut,
  output wire        dqOe_n,
  input  wire [7:0]  dqIn,
  output wire        chipSel_n,
  output wire        outGate_n,
  output wire        writeStb_n
);

  localparam S_IDLE = 3'h0;
  localparam S_SEQ  = 3'h1;
  localparam S_POLL = 3'h2;
  localparam S_READ = 3'h3;
  localparam S_RST  = 3'h4;

  reg  [2:0]  st_q;
  reg  [2:0]  op_q;
  reg  [18:0] addr_q;
  reg  [7:0]  data_q;
  reg  [2:0]  idx_q;
  reg  [2:0]  len_q;
  reg         cycStart_q;
  reg         cycBusy_q;
  reg         cycWrite_q;
  reg  [18:0] cycAddr_q;
  reg  [7:0]  cycData_q;
  wire        cycDone;
  wire [7:0]  cycRd;

  reg  [18:0] seqAddr;
  reg  [7:0]  seqData;

  // ----------------------------------------------------------------
  // Command sequence table
  // ----------------------------------------------------------------
  always @* begin
    seqAddr = `UNLOCK_ADDR1;
    seqData = `UNLOCK_DATA1;
    case (idx_q)
      3'h0: begin
        seqAddr = `UNLOCK_ADDR1;
        seqData = `UNLOCK_DATA1;
      end
      3'h1, 3'h4: begin
        seqAddr = `UNLOCK_ADDR2;
        seqData = `UNLOCK_DATA2;
      end
      3'h2: begin
        seqAddr = `UNLOCK_ADDR1;
        if (op_q == `OP_PROGRAM) begin
          seqData = `CMD_PROGRAM;
        end else if (op_q == `OP_CHIP_ERASE) begin
          seqData = `CMD_ERASE_SETUP;
        end else begin
          seqData = `CMD_AUTOSELECT;
        end
      end
      3'h3: begin
        if (op_q == `OP_PROGRAM) begin
          seqAddr = addr_q;
          seqData = data_q;
        end else begin
          seqAddr = `UNLOCK_ADDR1;
          seqData = `UNLOCK_DATA1;
        end
      end
      3'h5: begin
        seqAddr = `UNLOCK_ADDR1;
        seqData = `CMD_CHIP_ERASE;
      end
      default: begin
        seqAddr = `UNLOCK_ADDR1;
        seqData = `UNLOCK_DATA1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycStart_q <= 1'b0;
    opDone     <= 1'b0;
    if (sys_rst) begin
      // Device powers up in array read
      st_q          <= S_IDLE;
      op_q          <= `OP_READ;
      addr_q        <= 19'h00000;
      data_q        <= 8'h00;
      idx_q         <= 3'h0;
      len_q         <= 3'h0;
      cycBusy_q     <= 1'b0;
      cycWrite_q    <= 1'b0;
      cycAddr_q     <= 19'h00000;
      cycData_q     <= 8'h00;
      opReady       <= 1'b0;
      opError       <= 1'b0;
      opRdData      <= 8'h00;
      busy          <= 1'b0;
      autoselActive <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          opReady <= 1'b1;
          if (opValid && opReady) begin
            opReady <= 1'b0;
            op_q    <= opCode;
            addr_q  <= opAddr;
            data_q  <= opData;
            idx_q   <= 3'h0;
            opError <= 1'b0;
            case (opCode)
              `OP_PROGRAM: begin
                // Bits may only be cleared
                data_q <= opData;
                len_q  <= 3'h4;
                st_q   <= S_SEQ;
              end
              `OP_CHIP_ERASE: begin
                len_q <= 3'h6;
                st_q  <= S_SEQ;
              end
              `OP_AUTOSELECT: begin
                len_q <= 3'h3;
                st_q  <= S_SEQ;
              end
              `OP_RESET: begin
                // Address is free for reset
                cycAddr_q  <= opAddr;
                cycData_q  <= `CMD_RESET;
                cycWrite_q <= 1'b1;
                cycStart_q <= 1'b1;
                st_q       <= S_RST;
              end
              default: begin
                cycAddr_q  <= opAddr;
                cycWrite_q <= 1'b0;
                cycStart_q <= 1'b1;
                st_q       <= S_READ;
              end
            endcase
          end
        end
        S_SEQ: begin
          // One pin cycle at a time, next only after done
          if (!cycBusy_q && idx_q < len_q) begin
            cycAddr_q  <= seqAddr;
            cycData_q  <= seqData;
            cycWrite_q <= 1'b1;
            cycStart_q <= 1'b1;
            cycBusy_q  <= 1'b1;
            idx_q      <= idx_q + 3'h1;
          end else if (cycDone) begin
            cycBusy_q <= 1'b0;
            if (idx_q == len_q) begin
              if (op_q == `OP_AUTOSELECT) begin
                autoselActive <= 1'b1;
                opDone        <= 1'b1;
                st_q          <= S_IDLE;
              end else begin
                // No commands until the operation ends
                busy       <= 1'b1;
                cycAddr_q  <= addr_q;
                cycWrite_q <= 1'b0;
                cycStart_q <= 1'b1;
                st_q       <= S_POLL;
              end
            end
          end
        end
        S_POLL: begin
          if (cycDone) begin
            if ((op_q == `OP_CHIP_ERASE) ? cycRd[`DATA_POLL_BIT] :
                (cycRd[`DATA_POLL_BIT] == data_q[`DATA_POLL_BIT])) begin
              busy     <= 1'b0;
              opRdData <= cycRd;
              opDone   <= 1'b1;
              st_q     <= S_IDLE;
            end else if (cycRd[`TIMEOUT_BIT]) begin
              // Failure clears only by reset
              opError    <= 1'b1;
              cycAddr_q  <= addr_q;
              cycData_q  <= `CMD_RESET;
              cycWrite_q <= 1'b1;
              cycStart_q <= 1'b1;
              st_q       <= S_RST;
            end else begin
              cycStart_q <= 1'b1;
            end
          end
        end
        S_READ: begin
          if (cycDone) begin
            opRdData <= cycRd;
            opDone   <= 1'b1;
            st_q     <= S_IDLE;
          end
        end
        S_RST: begin
          if (cycDone) begin
            autoselActive <= 1'b0;
            busy          <= 1'b0;
            opDone        <= 1'b1;
            st_q          <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------
  bus_cycle_engine u_cycle (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (cycStart_q),
    .isWrite    (cycWrite_q),
    .addrIn     (cycAddr_q),
    .dataIn     (cycData_q),
    .done       (cycDone),
    .rdData     (cycRd),
    .flashAddr  (flashAddr),
    .dqOut      (dqOut),
    .dqOe_n     (dqOe_n),
    .dqIn       (dqIn),
    .chipSel_n  (chipSel_n),
    .outGate_n  (outGate_n),
    .writeStb_n (writeStb_n)
  );

endmodule // flash_command_state_machine
`default_nettype wire

// File: verilog/flash_host_defines.vh
// Constants for the parallel flash host controller
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ----------------------------------------------------------------
// Command cycle addresses and data
// ----------------------------------------------------------------
`define UNLOCK_ADDR1     19'h00555
`define UNLOCK_ADDR2     19'h002AA
`define UNLOCK_DATA1     8'hAA
`define UNLOCK_DATA2     8'h55
`define CMD_RESET        8'hF0
`define CMD_AUTOSELECT   8'h90
`define CMD_PROGRAM      8'hA0
`define CMD_ERASE_SETUP  8'h80
`define CMD_CHIP_ERASE   8'h10

// ----------------------------------------------------------------
// Autoselect read offsets
// ----------------------------------------------------------------
`define AS_MFR_OFFSET    8'h00
`define AS_DEV_OFFSET    8'h01
`define AS_PROT_OFFSET   8'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TIMEOUT_BIT      5
`define DATA_POLL_BIT    7
`define SECTOR_MSB       18
`define SECTOR_LSB       16

// ----------------------------------------------------------------
// Timing, in ns, and derived counts at 4 ns per cycle
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define SETUP_NS         20
`define PULSE_NS         40
`define HOLD_NS          20
`define SETUP_CYC  ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC  ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC   ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Operation codes on the user port
// ----------------------------------------------------------------
`define OP_READ          3'h0
`define OP_RESET         3'h1
`define OP_AUTOSELECT    3'h2
`define OP_PROGRAM       3'h3
`define OP_CHIP_ERASE    3'h4
`define OP_POLL          3'h5

`endif
